// ### rtl/ttc_timer_unit.sv
// three timer/counters with their special-function registers
`timescale 1ns/1ps
module ttc_timer_unit
    import ttc_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    input wire ttc_sfr_req_type i_sfr_req,
    input wire logic i_count_pin_zero,
    input wire logic i_count_pin_one,
    input wire logic i_count_pin_two,
    input wire logic i_timer0_gate_pin,
    input wire logic i_timer1_gate_pin,
    input wire logic i_capture_trigger_input,
    output logic [7:0] o_sfr_rdata,
    output logic o_timer0_irq,
    output logic o_timer1_irq,
    output logic o_timer2_irq,
    output logic o_uart_rx_baud_tick,
    output logic o_uart_tx_baud_tick
);

    localparam int PIN_COUNT0 = 0;
    localparam int PIN_COUNT1 = 1;
    localparam int PIN_COUNT2 = 2;
    localparam int PIN_TIMER0_GATE_PIN = 3;
    localparam int PIN_TIMER1_GATE_PIN = 4;
    localparam int PIN_TRIGGER = 5;
    localparam int PIN_NUM = 6;

    // one step of a timer in modes 0..2, and the low half of the split mode
    function automatic ttc_count_type tmr_step(input ttc_mode_type m, input logic [7:0] hi,
                                               input logic [7:0] lo);
        ttc_count_type r;
        r.overflow = 1'b0;
        r.high = hi;
        r.low = lo;
        unique case (m)
            TMR_MODE_13BIT: begin
                // upper three low-byte bits are left as software wrote them
                r.low[4:0] = lo[4:0] + 5'h01;
                if (lo[4:0] == 5'h1f) begin
                    r.high = hi + 8'h01;
                    r.overflow = (hi == 8'hff);
                end
            end
            TMR_MODE_16BIT: begin
                {r.high, r.low} = {hi, lo} + 16'h0001;
                r.overflow = ({hi, lo} == 16'hffff);
            end
            TMR_MODE_AUTO8: begin
                r.overflow = (lo == 8'hff);
                r.low = r.overflow ? hi : lo + 8'h01;
            end
            TMR_MODE_SPLIT: begin
                r.overflow = (lo == 8'hff);
                r.low = lo + 8'h01;
            end
        endcase
        return r;
    endfunction : tmr_step

    ttc_timer_control_flags_type timer_control_flags;
    logic [7:0] timer_mode_select;
    logic [7:0] clock_prescale_control;
    ttc_timer2_control_flags_type timer2_control_flags;
    logic [7:0] tl0, th0, tl1, th1, tl2, th2, rcap_lo, rcap_hi;
    logic [3:0] prescale;
    logic [PIN_NUM-1:0] pin_meta, pin_sync, pin_prev;

    // pin synchronisers: meta stage is read only by the sync stage
    wire [PIN_NUM-1:0] pin_raw = {i_capture_trigger_input, i_timer1_gate_pin,
                                  i_timer0_gate_pin, i_count_pin_two,
                                  i_count_pin_one, i_count_pin_zero};
    wire [PIN_NUM-1:0] pin_fall = pin_prev & ~pin_sync;

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pin_meta <= '1;
            pin_sync <= '1;
            pin_prev <= '1;
        end else begin
            pin_meta <= pin_raw;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    // shared free-running divider; 12 is a multiple of 4 and 2 so all ticks stay even
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            prescale <= 4'h0;
        end else begin
            prescale <= (prescale == PRESCALE_LAST) ? 4'h0 : prescale + 4'h1;
        end
    end

    wire tick_slow = (prescale == PRESCALE_LAST);
    wire tick_fast = ((prescale & FAST_MASK) == FAST_MASK);
    wire tick_baud = ((prescale & BAUD_MASK) == BAUD_MASK);

    // bus decode
    wire wr = i_sfr_req.write;
    wire [7:0] wdata = i_sfr_req.wdata;
    wire wr_timer_control_flags = wr && (i_sfr_req.addr == ADDR_TIMER_CONTROL_FLAGS);
    wire wr_timer_mode_select = wr && (i_sfr_req.addr == ADDR_TIMER_MODE_SELECT);
    wire wr_tl0 = wr && (i_sfr_req.addr == ADDR_TIMER0_COUNT_LOW);
    wire wr_tl1 = wr && (i_sfr_req.addr == ADDR_TIMER1_COUNT_LOW);
    wire wr_th0 = wr && (i_sfr_req.addr == ADDR_TIMER0_COUNT_HIGH);
    wire wr_th1 = wr && (i_sfr_req.addr == ADDR_TIMER1_COUNT_HIGH);
    wire wr_clock_prescale_control = wr && (i_sfr_req.addr == ADDR_CLOCK_PRESCALE_CONTROL);
    wire wr_timer2_control_flags = wr && (i_sfr_req.addr == ADDR_TIMER2_CONTROL_FLAGS);
    wire wr_rcap_lo = wr && (i_sfr_req.addr == ADDR_CAPTURE_LOW_BYTE);
    wire wr_rcap_hi = wr && (i_sfr_req.addr == ADDR_CAPTURE_HIGH_BYTE);
    wire wr_tl2 = wr && (i_sfr_req.addr == ADDR_TIMER2_LOW_BYTE);
    wire wr_th2 = wr && (i_sfr_req.addr == ADDR_TIMER2_HIGH_BYTE);

    // timers 0 and 1
    wire ttc_tmr_ctrl_type t0c = ttc_tmr_ctrl_type'(timer_mode_select[3:0]);
    wire ttc_tmr_ctrl_type t1c = ttc_tmr_ctrl_type'(timer_mode_select[FIELD_TIMER1_CTRL_LSB +: 4]);
    wire tick_t0 = clock_prescale_control[BIT_TIMER0_PRESCALE_SELECT] ? tick_fast : tick_slow;
    wire tick_t1 = clock_prescale_control[BIT_TIMER1_PRESCALE_SELECT] ? tick_fast : tick_slow;
    wire t0_split = (t0c.mode == TMR_MODE_SPLIT);
    wire run0 = timer_control_flags.timer0_run && (!t0c.gate || pin_sync[PIN_TIMER0_GATE_PIN]);
    wire run1 = timer_control_flags.timer1_run && (!t1c.gate || pin_sync[PIN_TIMER1_GATE_PIN])
                && (t1c.mode != TMR_MODE_SPLIT);
    wire src0 = t0c.counter_or_timer_select ? pin_fall[PIN_COUNT0] : tick_t0;
    wire src1 = t1c.counter_or_timer_select ? pin_fall[PIN_COUNT1] : tick_t1;
    wire inc0 = run0 && src0;
    wire inc1 = run1 && src1;
    // split high byte: timer only, gated by timer 1 run alone
    wire inc0_high = t0_split && timer_control_flags.timer1_run && tick_t0;
    wire ttc_count_type step0 = tmr_step(t0c.mode, th0, tl0);
    wire ttc_count_type step1 = tmr_step(t1c.mode, th1, tl1);
    wire ovf0 = inc0 && step0.overflow;
    wire ovf0_high = inc0_high && (th0 == 8'hff);
    wire ovf1 = inc1 && step1.overflow;
    wire set_tf0 = ovf0;
    wire set_tf1 = t0_split ? ovf0_high : ovf1;

    // timer 2
    wire baud2 = timer2_control_flags.uart_rx_clock_select || timer2_control_flags.uart_tx_clock_select;
    wire capture_mode = !baud2 && timer2_control_flags.capture_reload_select;
    wire reload_mode = !baud2 && !timer2_control_flags.capture_reload_select;
    wire tick_t2 = baud2 ? tick_baud
                 : (clock_prescale_control[BIT_TIMER2_PRESCALE_SELECT] ? tick_fast : tick_slow);
    wire src2 = timer2_control_flags.timer2_counter_select ? pin_fall[PIN_COUNT2] : tick_t2;
    wire inc2 = timer2_control_flags.timer2_run && src2;
    wire [15:0] cnt2 = {th2, tl2};
    wire [15:0] rcap = {rcap_hi, rcap_lo};
    wire ovf2 = inc2 && (cnt2 == 16'hffff);
    // a disabled trigger input is ignored entirely
    wire trig2 = pin_fall[PIN_TRIGGER] && timer2_control_flags.timer2_external_enable;
    wire reload2 = (ovf2 && (baud2 || reload_mode))
                 || (trig2 && reload_mode);
    wire capture2 = trig2 && capture_mode;
    wire set_tf2 = ovf2 && !baud2;
    wire set_timer2_external_flag = trig2;
    wire [15:0] cnt2_hw = reload2 ? rcap : (inc2 ? cnt2 + 16'h0001 : cnt2);
    wire [15:0] rcap_hw = capture2 ? cnt2 : rcap;

    // next values: a software write to a register wins over counting
    wire [7:0] next_tl0 = wr_tl0 ? wdata : (inc0 ? step0.low : tl0);
    wire [7:0] next_th0 = wr_th0 ? wdata
                        : (t0_split ? (inc0_high ? th0 + 8'h01 : th0)
                        : (inc0 ? step0.high : th0));
    wire [7:0] next_tl1 = wr_tl1 ? wdata : (inc1 ? step1.low : tl1);
    wire [7:0] next_th1 = wr_th1 ? wdata : (inc1 ? step1.high : th1);
    wire [7:0] next_tl2 = wr_tl2 ? wdata : cnt2_hw[7:0];
    wire [7:0] next_th2 = wr_th2 ? wdata : cnt2_hw[15:8];
    wire [7:0] next_rcap_lo = wr_rcap_lo ? wdata : rcap_hw[7:0];
    wire [7:0] next_rcap_hi = wr_rcap_hi ? wdata : rcap_hw[15:8];

    // flags: hardware set wins over a software clear in the same cycle
    ttc_timer_control_flags_type next_timer_control_flags;
    ttc_timer2_control_flags_type next_timer2_control_flags;
    always_comb begin
        next_timer_control_flags = wr_timer_control_flags ? ttc_timer_control_flags_type'(wdata) : timer_control_flags;
        next_timer_control_flags.timer0_overflow_flag = next_timer_control_flags.timer0_overflow_flag || set_tf0;
        next_timer_control_flags.timer1_overflow_flag = next_timer_control_flags.timer1_overflow_flag || set_tf1;
        next_timer2_control_flags = wr_timer2_control_flags ? ttc_timer2_control_flags_type'(wdata) : timer2_control_flags;
        next_timer2_control_flags.timer2_overflow_flag = next_timer2_control_flags.timer2_overflow_flag || set_tf2;
        next_timer2_control_flags.timer2_external_flag = next_timer2_control_flags.timer2_external_flag || set_timer2_external_flag;
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            timer_control_flags <= ttc_timer_control_flags_type'(RST_TIMER_CONTROL_FLAGS);
            timer_mode_select <= RST_TIMER_MODE_SELECT;
            clock_prescale_control <= RST_CLOCK_PRESCALE_CONTROL;
            timer2_control_flags <= ttc_timer2_control_flags_type'(RST_TIMER2_CONTROL_FLAGS);
        end else begin
            timer_control_flags <= next_timer_control_flags;
            timer_mode_select <= wr_timer_mode_select ? wdata : timer_mode_select;
            clock_prescale_control <= wr_clock_prescale_control ? wdata : clock_prescale_control;
            timer2_control_flags <= next_timer2_control_flags;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            tl0 <= RST_COUNT_BYTE;
            th0 <= RST_COUNT_BYTE;
            tl1 <= RST_COUNT_BYTE;
            th1 <= RST_COUNT_BYTE;
            tl2 <= RST_COUNT_BYTE;
            th2 <= RST_COUNT_BYTE;
            rcap_lo <= RST_COUNT_BYTE;
            rcap_hi <= RST_COUNT_BYTE;
        end else begin
            tl0 <= next_tl0;
            th0 <= next_th0;
            tl1 <= next_tl1;
            th1 <= next_th1;
            tl2 <= next_tl2;
            th2 <= next_th2;
            rcap_lo <= next_rcap_lo;
            rcap_hi <= next_rcap_hi;
        end
    end

    // read mux; unmapped addresses read zero
    logic [7:0] rd_mux;
    always_comb begin
        unique case (i_sfr_req.addr)
            ADDR_TIMER_CONTROL_FLAGS: rd_mux = timer_control_flags;
            ADDR_TIMER_MODE_SELECT: rd_mux = timer_mode_select;
            ADDR_TIMER0_COUNT_LOW: rd_mux = tl0;
            ADDR_TIMER1_COUNT_LOW: rd_mux = tl1;
            ADDR_TIMER0_COUNT_HIGH: rd_mux = th0;
            ADDR_TIMER1_COUNT_HIGH: rd_mux = th1;
            ADDR_CLOCK_PRESCALE_CONTROL: rd_mux = clock_prescale_control;
            ADDR_TIMER2_CONTROL_FLAGS: rd_mux = timer2_control_flags;
            ADDR_CAPTURE_LOW_BYTE: rd_mux = rcap_lo;
            ADDR_CAPTURE_HIGH_BYTE: rd_mux = rcap_hi;
            ADDR_TIMER2_LOW_BYTE: rd_mux = tl2;
            ADDR_TIMER2_HIGH_BYTE: rd_mux = th2;
            default: rd_mux = 8'h00;
        endcase
    end

    // interrupt outputs registered from next flag values so flags and requests line up; read data from current values
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_sfr_rdata <= 8'h00;
            o_timer0_irq <= 1'b0;
            o_timer1_irq <= 1'b0;
            o_timer2_irq <= 1'b0;
            o_uart_rx_baud_tick <= 1'b0;
            o_uart_tx_baud_tick <= 1'b0;
        end else begin
            o_sfr_rdata <= rd_mux;
            o_timer0_irq <= next_timer_control_flags.timer0_overflow_flag;
            o_timer1_irq <= next_timer_control_flags.timer1_overflow_flag;
            o_timer2_irq <= next_timer2_control_flags.timer2_overflow_flag
                            || next_timer2_control_flags.timer2_external_flag;
            o_uart_rx_baud_tick <= next_timer2_control_flags.uart_rx_clock_select ? ovf2 : ovf1;
            o_uart_tx_baud_tick <= next_timer2_control_flags.uart_tx_clock_select ? ovf2 : ovf1;
        end
    end

endmodule : ttc_timer_unit

// ### rtl/ttc_pkg.sv
// constants, field layouts and carrier types for the triple timer/counter unit
package ttc_pkg;

    localparam logic [7:0] ADDR_TIMER_CONTROL_FLAGS = 8'h88;
    localparam logic [7:0] ADDR_TIMER_MODE_SELECT = 8'h89;
    localparam logic [7:0] ADDR_TIMER0_COUNT_LOW = 8'h8a;
    localparam logic [7:0] ADDR_TIMER1_COUNT_LOW = 8'h8b;
    localparam logic [7:0] ADDR_TIMER0_COUNT_HIGH = 8'h8c;
    localparam logic [7:0] ADDR_TIMER1_COUNT_HIGH = 8'h8d;
    localparam logic [7:0] ADDR_CLOCK_PRESCALE_CONTROL = 8'h8e;
    localparam logic [7:0] ADDR_TIMER2_CONTROL_FLAGS = 8'hc8;
    localparam logic [7:0] ADDR_CAPTURE_LOW_BYTE = 8'hca;
    localparam logic [7:0] ADDR_CAPTURE_HIGH_BYTE = 8'hcb;
    localparam logic [7:0] ADDR_TIMER2_LOW_BYTE = 8'hcc;
    localparam logic [7:0] ADDR_TIMER2_HIGH_BYTE = 8'hcd;

    localparam logic [7:0] RST_TIMER_CONTROL_FLAGS = 8'h00;
    localparam logic [7:0] RST_TIMER_MODE_SELECT = 8'h00;
    localparam logic [7:0] RST_CLOCK_PRESCALE_CONTROL = 8'h03;
    localparam logic [7:0] RST_TIMER2_CONTROL_FLAGS = 8'h00;
    localparam logic [7:0] RST_COUNT_BYTE = 8'h00;

    // prescale bit positions in the clock prescale control register
    localparam int BIT_TIMER2_PRESCALE_SELECT = 5;
    localparam int BIT_TIMER1_PRESCALE_SELECT = 4;
    localparam int BIT_TIMER0_PRESCALE_SELECT = 3;
    // timer 1 control nibble sits above timer 0 nibble in the mode register
    localparam int FIELD_TIMER1_CTRL_LSB = 4;

    localparam int DIV_SLOW = 12;
    localparam int DIV_FAST = 4;
    localparam int DIV_BAUD = 2;
    localparam logic [3:0] PRESCALE_LAST = 4'(DIV_SLOW - 1);
    localparam logic [3:0] FAST_MASK = 4'(DIV_FAST - 1);
    localparam logic [3:0] BAUD_MASK = 4'(DIV_BAUD - 1);

    typedef enum logic [1:0] {
        TMR_MODE_13BIT = 2'b00,
        TMR_MODE_16BIT = 2'b01,
        TMR_MODE_AUTO8 = 2'b10,
        TMR_MODE_SPLIT = 2'b11
    } ttc_mode_type;

    typedef struct packed {
        logic gate;
        logic counter_or_timer_select;
        ttc_mode_type mode;
    } ttc_tmr_ctrl_type;

    typedef struct packed {
        logic timer1_overflow_flag;
        logic timer1_run;
        logic timer0_overflow_flag;
        logic timer0_run;
        logic [3:0] ext_irq_bits;
    } ttc_timer_control_flags_type;

    typedef struct packed {
        logic timer2_overflow_flag;
        logic timer2_external_flag;
        logic uart_rx_clock_select;
        logic uart_tx_clock_select;
        logic timer2_external_enable;
        logic timer2_run;
        logic timer2_counter_select;
        logic capture_reload_select;
    } ttc_timer2_control_flags_type;

    typedef struct packed {
        logic overflow;
        logic [7:0] high;
        logic [7:0] low;
    } ttc_count_type;

    typedef struct packed {
        logic write;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ttc_sfr_req_type;

endpackage : ttc_pkg

// ### sim/ttc_chk.sv
// port-level assertions for the triple timer/counter unit
`timescale 1ns/1ps
module ttc_chk
    import ttc_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    input wire ttc_sfr_req_type i_sfr_req,
    input wire logic i_count_pin_zero,
    input wire logic i_count_pin_one,
    input wire logic i_count_pin_two,
    input wire logic i_timer0_gate_pin,
    input wire logic i_timer1_gate_pin,
    input wire logic i_capture_trigger_input,
    input wire logic [7:0] o_sfr_rdata,
    input wire logic o_timer0_irq,
    input wire logic o_timer1_irq,
    input wire logic o_timer2_irq,
    input wire logic o_uart_rx_baud_tick,
    input wire logic o_uart_tx_baud_tick
);
    // software copies of control bits that hardware never changes
    logic run0;
    logic [7:0] timer_mode_select;
    logic [5:3] timer2_control_flags;
    wire logic timer_control_flags_wr = i_sfr_req.write && i_sfr_req.addr == ADDR_TIMER_CONTROL_FLAGS;
    wire logic timer_mode_select_wr = i_sfr_req.write && i_sfr_req.addr == ADDR_TIMER_MODE_SELECT;
    wire logic t2_wr = i_sfr_req.write && i_sfr_req.addr == ADDR_TIMER2_CONTROL_FLAGS;
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            run0 <= 1'b0;
            timer_mode_select <= 8'h00;
            timer2_control_flags <= 3'h0;
        end else begin
            run0 <= timer_control_flags_wr ? i_sfr_req.wdata[4] : run0;
            timer_mode_select <= timer_mode_select_wr ? i_sfr_req.wdata : timer_mode_select;
            timer2_control_flags <= t2_wr ? i_sfr_req.wdata[5:3] : timer2_control_flags;
        end
    end
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_arst_n);
    flag0_hold_a: assert property (o_timer0_irq && !(timer_control_flags_wr && !i_sfr_req.wdata[5])
        |=> o_timer0_irq) else $error("timer 0 flag fell without a clear");
    flag1_hold_a: assert property (o_timer1_irq && !(timer_control_flags_wr && !i_sfr_req.wdata[7])
        |=> o_timer1_irq) else $error("timer 1 flag fell without a clear");
    t2_irq_hold_a: assert property (o_timer2_irq
        && !(t2_wr && i_sfr_req.wdata[7:6] == 2'b00) |=> o_timer2_irq)
        else $error("timer 2 request fell without a clear");
    stop0_quiet_a: assert property (!run0 && !timer_control_flags_wr |=> !$rose(o_timer0_irq))
        else $error("timer 0 flag rose while stopped");
    t1_frozen_a: assert property (timer_mode_select[5:4] == 2'b11 && timer_mode_select[1:0] != 2'b11
        && !timer_control_flags_wr |=> !$rose(o_timer1_irq)) else $error("timer 1 counted in mode 3");
    baud_no_flag_a: assert property (timer2_control_flags[5:4] != 2'b00 && !timer2_control_flags[3] && !t2_wr
        |=> !$rose(o_timer2_irq)) else $error("timer 2 flag set in baud mode");
    rx_pulse_a: assert property (o_uart_rx_baud_tick |=> !o_uart_rx_baud_tick)
        else $error("rx baud tick longer than one cycle");
    unmapped_zero_a: assert property (i_sfr_req.addr < ADDR_TIMER_CONTROL_FLAGS
        |=> o_sfr_rdata == 8'h00) else $error("unmapped read not zero");
    mode_rdbk_a: assert property (timer_mode_select_wr ##1 i_sfr_req.addr == ADDR_TIMER_MODE_SELECT
        |=> o_sfr_rdata == $past(i_sfr_req.wdata, 2)) else $error("mode readback wrong");
endmodule : ttc_chk

bind ttc_timer_unit ttc_chk u_ttc_chk (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n),
    .i_sfr_req(i_sfr_req), .i_count_pin_zero(i_count_pin_zero),
    .i_count_pin_one(i_count_pin_one), .i_count_pin_two(i_count_pin_two),
    .i_timer0_gate_pin(i_timer0_gate_pin), .i_timer1_gate_pin(i_timer1_gate_pin),
    .i_capture_trigger_input(i_capture_trigger_input), .o_sfr_rdata(o_sfr_rdata),
    .o_timer0_irq(o_timer0_irq), .o_timer1_irq(o_timer1_irq), .o_timer2_irq(o_timer2_irq),
    .o_uart_rx_baud_tick(o_uart_rx_baud_tick), .o_uart_tx_baud_tick(o_uart_tx_baud_tick));

// ### sim/ttc_pins.sv
// model of the external count, gate and trigger pins
`timescale 1ns/1ps
module ttc_pins (
    input wire logic i_clk,
    output logic [5:0] o_pin
);
    // idle high so the synchronisers never see a stray falling edge
    initial o_pin = 6'h3f;
    // low and high phases span several clocks so the sampled pin sees each level
    task automatic fall(input int i);
        @(posedge i_clk);
        #1 o_pin[i] = 1'b0;
        repeat (3) @(posedge i_clk);
        #1 o_pin[i] = 1'b1;
        repeat (4) @(posedge i_clk);
        #1;
    endtask : fall
    task automatic hold(input int i, input logic v);
        @(posedge i_clk);
        #1 o_pin[i] = v;
        repeat (4) @(posedge i_clk);
        #1;
    endtask : hold
endmodule : ttc_pins

// ### sim/tb.sv
// self-checking bench for the triple timer/counter unit
`timescale 1ns/1ps
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin errors++; \
    $display("CHECK FAILED %s expected %h seen %h", n, e, a); end end
module tb
    import ttc_pkg::*;
;
    logic i_sys_clk = 1'b0;
    logic i_arst_n = 1'b0;
    ttc_sfr_req_type req = '0;
    logic [5:0] pin;
    logic [7:0] rdata;
    logic [2:0] irq;
    logic rx_tick;
    logic tx_tick;
    int errors = 0;
    int tests_run = 0;
    logic [7:0] cnt [8] = '{8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'hca, 8'hcb, 8'hcc, 8'hcd};
    logic [7:0] run_a [3] = '{8'h88, 8'h88, 8'hc8};
    logic [7:0] run_d [3] = '{8'h10, 8'h40, 8'h04};
    always #50 i_sys_clk = ~i_sys_clk;
    ttc_pins pins (.i_clk(i_sys_clk), .o_pin(pin));
    ttc_timer_unit dut (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_sfr_req(req),
        .i_count_pin_zero(pin[0]), .i_count_pin_one(pin[1]), .i_count_pin_two(pin[2]),
        .i_timer0_gate_pin(pin[3]), .i_timer1_gate_pin(pin[4]),
        .i_capture_trigger_input(pin[5]), .o_sfr_rdata(rdata),
        .o_timer0_irq(irq[0]), .o_timer1_irq(irq[1]), .o_timer2_irq(irq[2]),
        .o_uart_rx_baud_tick(rx_tick), .o_uart_tx_baud_tick(tx_tick));
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_sys_clk);
        #1 req = '{write: 1'b1, addr: a, wdata: d};
        @(posedge i_sys_clk);
        #1 req.write = 1'b0;
    endtask : wr
    task automatic chk_rd(input string n, input logic [7:0] a, input logic [7:0] e);
        @(posedge i_sys_clk);
        #1 req.addr = a;
        @(posedge i_sys_clk);
        #1;
        `CHK(n, e, rdata)
    endtask : chk_rd
    // cycles between two overflow flags, clearing the first one in between
    task automatic gap(input int t, input logic [7:0] a, input logic [7:0] d, output int n);
        n = 0;
        for (int k = 0; k < 2; k++) begin
            while (irq[t] !== 1'b1 && n < 100) begin
                @(posedge i_sys_clk);
                #1 n++;
            end
            if (k == 0) begin
                wr(a, d);
                n = 2;
            end
        end
    endtask : gap
    task automatic trig(input logic [7:0] c, input logic [7:0] tl, input logic [7:0] cx);
        wr(ADDR_TIMER2_LOW_BYTE, 8'h00);
        wr(ADDR_TIMER2_CONTROL_FLAGS, c);
        pins.fall(5);
        chk_rd("timer2 low", ADDR_TIMER2_LOW_BYTE, tl);
        chk_rd("timer2 flags", ADDR_TIMER2_CONTROL_FLAGS, cx);
    endtask : trig
    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : complete_run
    initial begin
        repeat (20000) @(posedge i_sys_clk);
        errors++;
        $display("watchdog expired");
        complete_run();
    end
    initial begin
        int n;
        int rx;
        int tx;
        repeat (20) @(posedge i_sys_clk);
        #1 i_arst_n = 1'b1;
        chk_rd("control", ADDR_TIMER_CONTROL_FLAGS, RST_TIMER_CONTROL_FLAGS);
        chk_rd("mode", ADDR_TIMER_MODE_SELECT, RST_TIMER_MODE_SELECT);
        chk_rd("prescale", ADDR_CLOCK_PRESCALE_CONTROL, RST_CLOCK_PRESCALE_CONTROL);
        chk_rd("timer2 ctl", ADDR_TIMER2_CONTROL_FLAGS, RST_TIMER2_CONTROL_FLAGS);
        chk_rd("unmapped", 8'h80, 8'h00);
        foreach (cnt[i]) begin
            wr(cnt[i], 8'(8'h11 * (i + 1)));
            chk_rd("count byte", cnt[i], 8'(8'h11 * (i + 1)));
        end
        $display("test registers done");
        for (int k = 0; k < 6; k++) begin
            wr(ADDR_TIMER_CONTROL_FLAGS, 8'h00);
            wr(ADDR_TIMER2_CONTROL_FLAGS, 8'h00);
            wr(ADDR_TIMER_MODE_SELECT, 8'h22);
            wr(ADDR_CLOCK_PRESCALE_CONTROL, (k / 3) ? 8'h38 : 8'h00);
            foreach (cnt[i]) wr(cnt[i], 8'hff);
            wr(run_a[k % 3], run_d[k % 3]);
            gap(k % 3, run_a[k % 3], run_d[k % 3], n);
            `CHK("tick gap", (k / 3) ? 8'd4 : 8'd12, 8'(n))
        end
        $display("test prescale done");
        wr(ADDR_TIMER_CONTROL_FLAGS, 8'h00);
        wr(ADDR_TIMER_MODE_SELECT, 8'h7d);
        foreach (cnt[i]) wr(cnt[i], 8'h00);
        wr(ADDR_TIMER_CONTROL_FLAGS, 8'h50);
        repeat (3) pins.fall(0);
        pins.fall(1);
        chk_rd("timer0 events", ADDR_TIMER0_COUNT_LOW, 8'h03);
        chk_rd("timer1 held", ADDR_TIMER1_COUNT_LOW, 8'h00);
        wr(ADDR_TIMER_MODE_SELECT, 8'h7c);
        wr(ADDR_TIMER0_COUNT_LOW, 8'hff);
        pins.fall(0);
        chk_rd("mode0 carry", ADDR_TIMER0_COUNT_HIGH, 8'h01);
        chk_rd("mode0 low", ADDR_TIMER0_COUNT_LOW, 8'he0);
        pins.hold(3, 1'b0);
        pins.fall(0);
        chk_rd("gated", ADDR_TIMER0_COUNT_LOW, 8'he0);
        $display("test counter done");
        // timer 0 split: high byte counts on timer 1 run alone and raises timer 1 flag
        wr(ADDR_TIMER_CONTROL_FLAGS, 8'h00);
        wr(ADDR_TIMER_MODE_SELECT, 8'h03);
        wr(ADDR_TIMER0_COUNT_LOW, 8'h55);
        wr(ADDR_TIMER0_COUNT_HIGH, 8'hff);
        wr(ADDR_TIMER_CONTROL_FLAGS, 8'h40);
        repeat (8) @(posedge i_sys_clk);
        chk_rd("split flags", ADDR_TIMER_CONTROL_FLAGS, 8'hc0);
        chk_rd("split low", ADDR_TIMER0_COUNT_LOW, 8'h55);
        $display("test split done");
        // timer 2 is still running from the prescale test; stop it so counts stay put
        wr(ADDR_TIMER2_CONTROL_FLAGS, 8'h00);
        wr(ADDR_TIMER2_HIGH_BYTE, 8'h00);
        wr(ADDR_CAPTURE_LOW_BYTE, 8'h34);
        wr(ADDR_CAPTURE_HIGH_BYTE, 8'h12);
        trig(8'h06, 8'h00, 8'h06);
        trig(8'h0e, 8'h34, 8'h4e);
        trig(8'h3e, 8'h00, 8'h7e);
        trig(8'h0f, 8'h00, 8'h4f);
        chk_rd("capture low", ADDR_CAPTURE_LOW_BYTE, 8'h00);
        `CHK("timer2 irq", 1'b1, irq[2])
        pins.fall(2);
        chk_rd("timer2 events", ADDR_TIMER2_LOW_BYTE, 8'h01);
        wr(ADDR_TIMER2_LOW_BYTE, 8'hff);
        wr(ADDR_TIMER2_HIGH_BYTE, 8'hff);
        pins.fall(2);
        chk_rd("capture wrap", ADDR_TIMER2_HIGH_BYTE, 8'h00);
        chk_rd("capture ovf", ADDR_TIMER2_CONTROL_FLAGS, 8'hcf);
        $display("test trigger done");
        foreach (cnt[i]) wr(cnt[i], 8'hff);
        wr(ADDR_TIMER2_CONTROL_FLAGS, 8'h34);
        rx = 0;
        tx = 0;
        repeat (4) @(posedge i_sys_clk);
        repeat (20) begin
            @(posedge i_sys_clk);
            #1 rx += int'(rx_tick === 1'b1);
            tx += int'(tx_tick === 1'b1);
        end
        `CHK("rx ticks", 10, rx)
        `CHK("tx ticks", 10, tx)
        `CHK("baud irq", 1'b0, irq[2])
        $display("test baud done");
        complete_run();
    end
endmodule : tb
